// ### logic/sfom_top.sv
// Receiver control with contactor feedback check, lock-out and lamps
`timescale 1ns/1ps
module sfom_top #(
    parameter int unsigned CFG_CYC = sfom_pkg::CFG_CYC,
    parameter int unsigned WIDE_CYC = sfom_pkg::WIDE_CYC,
    parameter int unsigned NC_CYC = sfom_pkg::NC_CYC,
    parameter int unsigned CHK_CYC = sfom_pkg::CHK_CYC,
    parameter int unsigned FLASH_CYC = sfom_pkg::FLASH_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic beam_clear,
    input wire logic contactor_feedback_check_en,
    input wire logic restart_lock_en,
    input wire logic contactor_dropped,
    input wire logic reset_button,
    input wire logic internal_defect,
    input wire logic needs_cleaning,
    input wire logic wide_field_unit,
    input wire logic non_coded,
    input wire logic sender_test_in,
    input wire logic supply_good,
    input wire logic sender_defect,
    output logic safety_switching_outputs,
    output logic lamp_green,
    output logic lamp_red,
    output logic lamp_yellow,
    output logic lamp_orange,
    output logic [3:0] rx_display,
    output logic emitter_on,
    output logic tx_lamp_yellow,
    output logic [3:0] tx_display
);
    // ==========================================================
    // Parameter checks
    if (CFG_CYC < 1 || WIDE_CYC < 1 || NC_CYC < 1 || CHK_CYC < 1 || FLASH_CYC < 1) begin
        $error("sfom_top: every cycle count must be at least one");
    end

    // ==========================================================
    // Helpers
    // True on the last cycle of a span of lim cycles
    function automatic logic sfom_last(input logic [31:0] cnt, input logic [31:0] lim);
        sfom_last = (cnt == lim - 32'h1);
    endfunction

    // ==========================================================
    // Declarations
    sfom_link_if link ();

    sfom_pkg::sfom_state_t state_r;
    sfom_pkg::sfom_state_t state_nxt;
    logic [31:0] timer_r;
    logic [31:0] timer_nxt;
    logic lock_sys_r;
    logic lock_sys_nxt;
    logic drop_ok;

    logic btn_prev_r;
    logic btn_prev_nxt;
    logic press;

    logic [31:0] flash_cnt_r;
    logic [31:0] flash_cnt_nxt;
    logic flash_r;
    logic flash_nxt;

    logic out_r;
    logic out_nxt;
    logic green_r;
    logic green_nxt;
    logic red_r;
    logic red_nxt;
    logic yellow_r;
    logic yellow_nxt;
    logic orange_r;
    logic orange_nxt;
    logic [3:0] disp_r;
    logic [3:0] disp_nxt;
    logic startup_r;
    logic startup_nxt;
    logic non_coded_r;
    logic non_coded_nxt;

    // ==========================================================
    // Sender
    sfom_sender u_sender (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .test_in(sender_test_in),
        .supply_good(supply_good),
        .tx_defect(sender_defect),
        .link(link.sender)
    );

    assign link.startup = startup_r;
    assign link.non_coded = non_coded_r;
    assign emitter_on = link.emit_on;
    assign tx_lamp_yellow = link.tx_yellow;
    assign tx_display = link.tx_disp;

    // ==========================================================
    // Reset button edge; idle level is low, so no false press after reset
    always_comb begin
        btn_prev_nxt = reset_button;
        press = reset_button && !btn_prev_r;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            btn_prev_r <= 1'b0;
        end else begin
            btn_prev_r <= btn_prev_nxt;
        end
    end

    // ==========================================================
    // Free-running flash clock for the reset request lamp
    always_comb begin
        if (sfom_last(flash_cnt_r, FLASH_CYC)) begin
            flash_cnt_nxt = 32'h0;
            flash_nxt = !flash_r;
        end else begin
            flash_cnt_nxt = flash_cnt_r + 32'h1;
            flash_nxt = flash_r;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            flash_cnt_r <= 32'h0;
            flash_r <= 1'b0;
        end else begin
            flash_cnt_r <= flash_cnt_nxt;
            flash_r <= flash_nxt;
        end
    end

    // ==========================================================
    // Receiver state machine
    always_comb begin
        state_nxt = state_r;
        timer_nxt = timer_r + 32'h1;
        lock_sys_nxt = lock_sys_r;
        // With the feedback check enabled, restart only with contactors proven dropped
        drop_ok = !contactor_feedback_check_en || contactor_dropped;
        case (state_r)
            sfom_pkg::ST_CFG: begin
                if (sfom_last(timer_r, CFG_CYC)) begin
                    if (wide_field_unit) begin
                        state_nxt = sfom_pkg::ST_WIDE;
                    end else if (non_coded) begin
                        state_nxt = sfom_pkg::ST_NC;
                    end else begin
                        state_nxt = sfom_pkg::ST_OFF;
                    end
                end
            end
            sfom_pkg::ST_WIDE: begin
                if (sfom_last(timer_r, WIDE_CYC)) begin
                    if (non_coded) begin
                        state_nxt = sfom_pkg::ST_NC;
                    end else begin
                        state_nxt = sfom_pkg::ST_OFF;
                    end
                end
            end
            sfom_pkg::ST_NC: begin
                if (sfom_last(timer_r, NC_CYC)) begin
                    state_nxt = sfom_pkg::ST_OFF;
                end
            end
            sfom_pkg::ST_OFF: begin
                if (beam_clear && drop_ok && (press || !restart_lock_en)) begin
                    state_nxt = sfom_pkg::ST_ON;
                end
            end
            sfom_pkg::ST_ON: begin
                if (!beam_clear) begin
                    if (contactor_feedback_check_en) begin
                        state_nxt = sfom_pkg::ST_CHECK;
                    end else begin
                        state_nxt = sfom_pkg::ST_OFF;
                    end
                end
            end
            sfom_pkg::ST_CHECK: begin
                if (contactor_dropped) begin
                    state_nxt = sfom_pkg::ST_OFF;
                end else if (sfom_last(timer_r, CHK_CYC)) begin
                    state_nxt = sfom_pkg::ST_FAIL;
                end
            end
            sfom_pkg::ST_FAIL: begin
                // A reset with the contactor still held means no safe state
                if (press) begin
                    if (contactor_dropped) begin
                        state_nxt = sfom_pkg::ST_OFF;
                    end else begin
                        state_nxt = sfom_pkg::ST_LOCK;
                    end
                end
            end
            sfom_pkg::ST_LOCK: begin
                state_nxt = sfom_pkg::ST_LOCK;
            end
            default: begin
                state_nxt = sfom_pkg::ST_LOCK;
            end
        endcase
        if (internal_defect && state_r != sfom_pkg::ST_LOCK) begin
            state_nxt = sfom_pkg::ST_LOCK;
            lock_sys_nxt = 1'b1;
        end
        if (state_nxt != state_r) begin
            timer_nxt = 32'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= sfom_pkg::ST_CFG;
            timer_r <= 32'h0;
            lock_sys_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            timer_r <= timer_nxt;
            lock_sys_r <= lock_sys_nxt;
        end
    end

    // ==========================================================
    // Outputs, lamps and display follow the next state
    always_comb begin
        disp_nxt = sfom_pkg::DISP_BLANK;
        startup_nxt = 1'b0;
        yellow_nxt = 1'b0;
        case (state_nxt)
            sfom_pkg::ST_CFG: begin
                disp_nxt = sfom_pkg::DISP_CFG_WAIT;
                startup_nxt = 1'b1;
            end
            sfom_pkg::ST_WIDE: begin
                disp_nxt = sfom_pkg::DISP_WIDE;
                startup_nxt = 1'b1;
            end
            sfom_pkg::ST_NC: begin
                disp_nxt = sfom_pkg::DISP_NON_CODED;
                startup_nxt = 1'b1;
            end
            sfom_pkg::ST_OFF: begin
                yellow_nxt = restart_lock_en;
            end
            sfom_pkg::ST_ON: begin
                disp_nxt = sfom_pkg::DISP_BLANK;
            end
            sfom_pkg::ST_CHECK: begin
                disp_nxt = sfom_pkg::DISP_BLANK;
            end
            sfom_pkg::ST_FAIL: begin
                disp_nxt = sfom_pkg::DISP_CHK_ERR;
                yellow_nxt = restart_lock_en && flash_nxt;
            end
            sfom_pkg::ST_LOCK: begin
                if (lock_sys_nxt) begin
                    disp_nxt = sfom_pkg::DISP_SYS_ERR;
                end else begin
                    disp_nxt = sfom_pkg::DISP_LOCKOUT;
                end
            end
            default: begin
                disp_nxt = sfom_pkg::DISP_LOCKOUT;
            end
        endcase
        // Outputs never on while a fault code stands
        out_nxt = (state_nxt == sfom_pkg::ST_ON) && !sfom_pkg::sfom_is_fault(disp_nxt);
        green_nxt = out_nxt;
        red_nxt = !out_nxt;
        orange_nxt = needs_cleaning && (state_nxt != sfom_pkg::ST_LOCK);
        non_coded_nxt = non_coded;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            out_r <= 1'b0;
            green_r <= 1'b0;
            red_r <= 1'b1;
            yellow_r <= 1'b0;
            orange_r <= 1'b0;
            disp_r <= sfom_pkg::DISP_CFG_WAIT;
            startup_r <= 1'b1;
            non_coded_r <= 1'b0;
        end else begin
            out_r <= out_nxt;
            green_r <= green_nxt;
            red_r <= red_nxt;
            yellow_r <= yellow_nxt;
            orange_r <= orange_nxt;
            disp_r <= disp_nxt;
            startup_r <= startup_nxt;
            non_coded_r <= non_coded_nxt;
        end
    end

    assign safety_switching_outputs = out_r;
    assign lamp_green = green_r;
    assign lamp_red = red_r;
    assign lamp_yellow = yellow_r;
    assign lamp_orange = orange_r;
    assign rx_display = disp_r;
endmodule

// ### logic/sfom_pkg.sv
// Constants, display codes and state type of the safety output monitor
// How it works
// - Check contactors drop after interruption and restart
// - Failed check: error code, outputs off, red
// - Failed check with restart lock: flash yellow
// - Unreachable safe state: lock, shut down, lockout code
// - Sender test input stops all beam emission
// - Sender test turns outputs off and red
// - Sender shows test code; yellow on supply good
// - Lamps: green on, red off, yellow, orange
// - Internal defect shows system error code, except once lockout already stands (lockout code kept)
// - Power-on: config wait code about 1 s
// - Power-on, 14 mm long range: wide code 0.5 s
// - Non-coded code only just after power-on
// - Codes outside status set mean a fault
// - Restart lock holds outputs off until reset press
package sfom_pkg;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_KHZ = 200000;
    localparam int unsigned T_CFG_MS = 1000;
    localparam int unsigned T_WIDE_MS = 500;
    localparam int unsigned T_NC_MS = 500;
    localparam int unsigned T_CHK_MS = 100;
    localparam int unsigned T_FLASH_MS = 250;
    localparam int unsigned CFG_CYC = T_CFG_MS * CLK_KHZ;
    localparam int unsigned WIDE_CYC = T_WIDE_MS * CLK_KHZ;
    localparam int unsigned NC_CYC = T_NC_MS * CLK_KHZ;
    localparam int unsigned CHK_CYC = T_CHK_MS * CLK_KHZ;
    localparam int unsigned FLASH_CYC = T_FLASH_MS * CLK_KHZ;

    // ==========================================================
    // Display codes; every code from DISP_ERR_BASE upward is a fault
    localparam logic [3:0] DISP_BLANK = 4'h0;
    localparam logic [3:0] DISP_CFG_WAIT = 4'h1;
    localparam logic [3:0] DISP_WIDE = 4'h2;
    localparam logic [3:0] DISP_NON_CODED = 4'h3;
    localparam logic [3:0] DISP_TEST = 4'h4;
    localparam logic [3:0] DISP_ERR_BASE = 4'h8;
    localparam logic [3:0] DISP_SYS_ERR = 4'h8;
    localparam logic [3:0] DISP_CHK_ERR = 4'h9;
    localparam logic [3:0] DISP_LOCKOUT = 4'hA;

    // ==========================================================
    // Receiver states
    typedef enum logic [2:0] {
        ST_CFG, ST_WIDE, ST_NC, ST_OFF, ST_ON, ST_CHECK, ST_FAIL, ST_LOCK
    } sfom_state_t;

    // Fault test on a display code
    function automatic logic sfom_is_fault(input logic [3:0] code);
        sfom_is_fault = (code >= DISP_ERR_BASE);
    endfunction

endpackage

// ### logic/sfom_link_if.sv
// Signals between the receiver control and the sender block
`timescale 1ns/1ps
interface sfom_link_if;
    logic startup;
    logic non_coded;
    logic emit_on;
    logic tx_yellow;
    logic [3:0] tx_disp;

    modport ctrl (output startup, output non_coded, input emit_on, input tx_yellow,
        input tx_disp);
    modport sender (input startup, input non_coded, output emit_on, output tx_yellow,
        output tx_disp);
endinterface

// ### logic/sfom_sender.sv
// Sender: test input blanking, lamp and display code
`timescale 1ns/1ps
module sfom_sender (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic test_in,
    input wire logic supply_good,
    input wire logic tx_defect,
    sfom_link_if.sender link
);
    logic emit_r;
    logic emit_nxt;
    logic yellow_r;
    logic yellow_nxt;
    logic [3:0] disp_r;
    logic [3:0] disp_nxt;

    // ==========================================================
    // Next values
    always_comb begin
        emit_nxt = supply_good && !test_in && !tx_defect;
        yellow_nxt = supply_good;
        if (tx_defect) begin
            disp_nxt = sfom_pkg::DISP_SYS_ERR;
        end else if (test_in) begin
            disp_nxt = sfom_pkg::DISP_TEST;
        end else if (link.startup && link.non_coded) begin
            disp_nxt = sfom_pkg::DISP_NON_CODED;
        end else begin
            disp_nxt = sfom_pkg::DISP_BLANK;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            emit_r <= 1'b0;
            yellow_r <= 1'b0;
            disp_r <= sfom_pkg::DISP_BLANK;
        end else begin
            emit_r <= emit_nxt;
            yellow_r <= yellow_nxt;
            disp_r <= disp_nxt;
        end
    end

    assign link.emit_on = emit_r;
    assign link.tx_yellow = yellow_r;
    assign link.tx_disp = disp_r;
endmodule

// ### tb/sfom_asserts.sv
// Port checker for the safety output monitor
`timescale 1ns/1ps
module sfom_asserts (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic sender_test_in,
    input wire logic supply_good,
    input wire logic safety_switching_outputs,
    input wire logic lamp_green,
    input wire logic lamp_red,
    input wire logic [3:0] rx_display,
    input wire logic emitter_on,
    input wire logic tx_lamp_yellow,
    input wire logic [3:0] tx_display
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    on_green_a: assert property (safety_switching_outputs |-> lamp_green && !lamp_red)
        else $error("green lamp wrong");
    off_red_a: assert property (!safety_switching_outputs |-> lamp_red)
        else $error("red lamp wrong");
    test_blank_a: assert property (sender_test_in |-> ##[0:4] !emitter_on)
        else $error("emitter still on");
    test_off_a: assert property (sender_test_in |-> ##[0:8] !safety_switching_outputs)
        else $error("outputs on in test");
    test_code_a: assert property (sender_test_in [*3] |-> tx_display == 4'h4)
        else $error("test code missing");
    tx_yellow_a: assert property (supply_good |-> ##[0:2] tx_lamp_yellow)
        else $error("sender yellow off");
    lock_hold_a: assert property (rx_display == 4'hA |=> rx_display == 4'hA)
        else $error("lockout left");
    lock_off_a: assert property (rx_display == 4'hA |-> !safety_switching_outputs)
        else $error("outputs on in lockout");
endmodule
bind sfom_top sfom_asserts u_chk (.*);

// ### tb/sfom_contactor_model.sv
// Machine contactor that reports its drop-out, optionally welded
`timescale 1ns/1ps
module sfom_contactor_model (
    input wire logic clk_sys,
    input wire logic coil_on,
    input wire logic welded,
    output logic dropped
);
    // A welded contactor never reports drop-out
    always @(posedge clk_sys) dropped <= !coil_on && !welded;
endmodule

// ### tb/testbench.sv
// Self-checking bench of the safety output monitor
`timescale 1ns/1ps
module testbench;
    logic clk_sys = 0, rst_b = 0, path_open = 1, contactor_feedback_check_en = 1;
    logic restart_lock_en = 1, reset_button = 0, internal_defect = 0, needs_cleaning = 0;
    logic wide_field_unit = 0, non_coded = 0, sender_test_in = 0, supply_good = 1;
    logic sender_defect = 0, welded = 0, contactor_dropped, safety_switching_outputs;
    logic lamp_green, lamp_red, lamp_yellow, lamp_orange, emitter_on, tx_lamp_yellow;
    logic [3:0] rx_display, tx_display;
    int mismatches = 0, check_count = 0, cyc = 0;
    // Receiver sees light only with an open path and an emitting sender
    wire beam_clear = path_open & emitter_on;
    sfom_top #(.CFG_CYC(20), .WIDE_CYC(10), .NC_CYC(10), .CHK_CYC(8), .FLASH_CYC(4)) DUT (.*);
    sfom_contactor_model u_cont (.clk_sys(clk_sys), .coil_on(safety_switching_outputs),
        .welded(welded), .dropped(contactor_dropped));
    always #2.5 clk_sys = ~clk_sys;
    task automatic print_verdict();
        $display("mismatches=%0d check_count=%0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk_sys) if (++cyc > 3000) begin
        mismatches++;
        print_verdict();
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic press();
        reset_button = 1;
        tick(3);
        reset_button = 0;
        tick(12);
    endtask
    task automatic run_interlock();
        press();
        chk(safety_switching_outputs, 1);
        path_open = 0;
        tick(12);
        chk({lamp_red, lamp_yellow, safety_switching_outputs}, 3'b110);
        path_open = 1;
        tick(20);
        chk(safety_switching_outputs, 0);
        press();
        chk(lamp_green, 1);
    endtask
    task automatic run_sender_test();
        sender_test_in = 1;
        tick(10);
        chk({emitter_on, tx_lamp_yellow, tx_display}, {2'b01, 4'h4});
        chk(safety_switching_outputs, 0);
        sender_test_in = 0;
        tick(20);
        press();
        chk(safety_switching_outputs, 1);
    endtask
    task automatic run_welded();
        logic y0;
        welded = 1;
        path_open = 0;
        tick(40);
        chk({safety_switching_outputs, lamp_red, rx_display >= 4'h8}, 3'b011);
        y0 = lamp_yellow;
        tick(4);
        chk(lamp_yellow, !y0);
        path_open = 1;
        press();
        chk(rx_display, 4'hA);
        press();
        chk({safety_switching_outputs, rx_display >= 4'h8}, 2'b01);
    endtask
    task automatic run_power_cycle();
        welded = 0;
        wide_field_unit = 1;
        non_coded = 1;
        rst_b = 0;
        tick(3);
        rst_b = 1;
        tick(2);
        chk(rx_display, 4'h1);
        tick(20);
        chk(rx_display, 4'h2);
        tick(10);
        chk({rx_display, tx_display}, 8'h33);
        needs_cleaning = 1;
        tick(2);
        chk(lamp_orange, 1);
        internal_defect = 1;
        tick(3);
        chk({safety_switching_outputs, rx_display}, 5'h08);
    endtask
    initial begin
        tick(12);
        rst_b = 1;
        tick(60);
        run_interlock();
        run_sender_test();
        run_welded();
        run_power_cycle();
        print_verdict();
    end
endmodule
